/* File: design/tps_edge_detect.sv */
// Edge detector for the demodulator input.
`timescale 1ns/10ps
`default_nettype none
module tps_edge_detect
  import tps_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Sample and selection
  input wire logic sample,
  input wire logic [1:0] edge_sel,
  // Result
  output logic hit
);

  typedef struct packed {
    logic last;
  } tps_edge_state_type;

  tps_edge_state_type state_q;
  tps_edge_state_type state_d;

  always_comb begin
    state_d = state_q;
    state_d.last = sample;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // --------------------------------------
  // Edge selection
  // --------------------------------------
  always_comb begin
    case (edge_sel)
      TPS_EDGE_FALL: hit = state_q.last & ~sample;
      TPS_EDGE_RISE: hit = ~state_q.last & sample;
      TPS_EDGE_BOTH: hit = state_q.last ^ sample;
      default: hit = 1'b0;
    endcase
  end

endmodule : tps_edge_detect
`default_nettype wire

/* File: design/tps_pkg.sv */
// Package with register map, field layouts and shared types of the timer pair shared control block.
package tps_pkg;

  // ----------------------------------------
  // Register addressing
  // ----------------------------------------
  localparam logic [7:0] TPS_ADDR_BANK_POINTER = 8'hfd;
  localparam logic [3:0] TPS_BANK_NORMAL = 4'h0;
  localparam logic [3:0] TPS_BANK_TIMER = 4'hd;
  localparam logic [3:0] TPS_BANK_F = 4'hf;
  localparam logic [3:0] TPS_IDX_TIMER8_CONTROL = 4'h0;
  localparam logic [3:0] TPS_IDX_SHARED_CONTROL = 4'h1;
  localparam logic [3:0] TPS_IDX_TIMER16_CONTROL = 4'h2;
  localparam logic [3:0] TPS_IDX_RESERVED = 4'h3;
  localparam logic [3:0] TPS_SHORT_PREFIX = 4'he;
  localparam int TPS_REGFILE_DEPTH = 256;
  localparam int TPS_BANK_DEPTH = 16;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TPS_SC_MODE = 7;
  localparam int TPS_SC_OUT6 = 6;
  localparam int TPS_SC_SEL_HI = 5;
  localparam int TPS_SC_SEL_LO = 4;
  localparam int TPS_T8_CAPT_IE = 2;
  localparam int TPS_T8_TOUT_IE = 1;
  localparam int TPS_T8_OUT4 = 0;
  localparam int TPS_T16_OUT5 = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TPS_RESET_CONTROL = 8'h00;
  localparam logic [7:0] TPS_RESET_POINTER = 8'h00;
  localparam logic [7:0] TPS_RESET_BYTE = 8'h00;

  // ----------------------------------------
  // Combine and edge codes
  // ----------------------------------------
  localparam logic [1:0] TPS_COMB_AND = 2'h0;
  localparam logic [1:0] TPS_COMB_OR = 2'h1;
  localparam logic [1:0] TPS_COMB_NOR = 2'h2;
  localparam logic [1:0] TPS_COMB_NAND = 2'h3;
  localparam logic [1:0] TPS_EDGE_FALL = 2'h0;
  localparam logic [1:0] TPS_EDGE_RISE = 2'h1;
  localparam logic [1:0] TPS_EDGE_BOTH = 2'h2;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tps_bus_type;

  typedef struct packed {
    logic short_out;
    logic long_out;
    logic short_timeout;
    logic short_capture;
  } tps_timer_type;

endpackage : tps_pkg

/* File: design/tps_shared_control.sv */
// Shared control, register banking and port 3 routing for the timer pair.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Port 3 low nibble is input only, high nibble push-pull output only.
// - Input comparators power down whenever stop mode is entered.
// - Timer and combined outputs route to port 3 by shared, timer8 and timer16 bits.
// - Pointer upper nibble picks the 16-byte working group of 256 bytes.
// - Pointer lower nibble selects expanded bank; banks 0, F, D exist.
// - Lower nibble zero addresses normal file; nonzero swaps bank into lowest 16.
// - Pointer 0Dh maps working regs 0,1,2 to the controls; 3 reserved.
// - Capture enable set requests interrupt on each demodulation capture.
// - Timeout enable set requests interrupt on timer8 timeout.
// - One bit picks port output or timer8 output for output bit four.
// - Shared bit 7 selects transmit (0, reset) or demodulation (1).
// - Shared bit 6 picks out6 source, or demodulator input in demodulation.
// - Transmit bits 5:4 combine outputs: AND, OR, NOR, NAND.
// - Combined output is the selected function of both timer outputs.
module tps_shared_control
  import tps_pkg::*;
(
  // Clock, reset and enable
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register file access from the core
  input wire tps_bus_type BUS,
  output logic [7:0] RDATA,
  // Timer engines
  input wire tps_timer_type TIMERS,
  output logic DEMOD_EDGE,
  output logic CAPTURE_IRQ,
  output logic TIMEOUT_IRQ,
  // Port pins and power
  input wire logic [3:0] PORT3_IN,
  input wire logic PORT2_BIT0,
  input wire logic [3:0] PORT3_LATCH,
  input wire logic STOP_MODE,
  output logic [7:4] PORT3_OUT,
  output logic COMPARATOR_EN,
  output logic [7:0] BANK_POINTER
);

  typedef struct packed {
    logic [7:0] pointer;
    logic [7:0] t8ctl;
    logic [7:0] shared;
    logic [7:0] t16ctl;
    logic [7:0] rdata;
    logic capt_irq;
    logic tout_irq;
    logic [7:4] pout;
    logic comp_en;
  } tps_state_type;

  tps_state_type state_q;
  tps_state_type state_d;
  logic [7:0] regfile_q [TPS_REGFILE_DEPTH];
  logic [7:0] bankf_q [TPS_BANK_DEPTH];
  logic [7:0] eff_addr;
  logic [3:0] bank;
  logic in_bank;
  logic demod_mode;
  logic demod_in;
  logic combined;
  logic edge_hit;
  logic [7:0] rd_val;

  // ------------------------------------------------------------------
  // Address resolution
  // ------------------------------------------------------------------
  always_comb begin
    bank = state_q.pointer[3:0];
    if (BUS.addr[7:4] == TPS_SHORT_PREFIX) begin
      eff_addr = {state_q.pointer[7:4], BUS.addr[3:0]};
    end else begin
      eff_addr = BUS.addr;
    end
    in_bank = (eff_addr[7:4] == 4'h0) && (bank != TPS_BANK_NORMAL);
  end

  always_comb begin
    rd_val = TPS_RESET_BYTE;
    if (eff_addr == TPS_ADDR_BANK_POINTER) begin
      rd_val = state_q.pointer;
    end else if (in_bank && bank == TPS_BANK_TIMER) begin
      case (eff_addr[3:0])
        TPS_IDX_TIMER8_CONTROL: rd_val = state_q.t8ctl;
        TPS_IDX_SHARED_CONTROL: rd_val = state_q.shared;
        TPS_IDX_TIMER16_CONTROL: rd_val = state_q.t16ctl;
        default: rd_val = TPS_RESET_BYTE;
      endcase
    end else if (in_bank && bank == TPS_BANK_F) begin
      rd_val = bankf_q[eff_addr[3:0]];
    end else if (!in_bank) begin
      rd_val = regfile_q[eff_addr];
    end
  end

  // ------------------------------------------------------------------
  // Timer output logic
  // ------------------------------------------------------------------
  assign demod_mode = state_q.shared[TPS_SC_MODE];
  assign demod_in = state_q.shared[TPS_SC_OUT6] ? PORT2_BIT0 : PORT3_IN[1];

  always_comb begin
    case (state_q.shared[TPS_SC_SEL_HI:TPS_SC_SEL_LO])
      TPS_COMB_AND: combined = TIMERS.short_out & TIMERS.long_out;
      TPS_COMB_OR: combined = TIMERS.short_out | TIMERS.long_out;
      TPS_COMB_NOR: combined = ~(TIMERS.short_out | TIMERS.long_out);
      TPS_COMB_NAND: combined = ~(TIMERS.short_out & TIMERS.long_out);
      default: combined = 1'b0;
    endcase
  end

  tps_edge_detect u_edge (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .sample(demod_in),
    .edge_sel(state_q.shared[TPS_SC_SEL_HI:TPS_SC_SEL_LO]),
    .hit(edge_hit)
  );

  assign DEMOD_EDGE = demod_mode & edge_hit;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.rdata = BUS.re ? rd_val : state_q.rdata;
    if (BUS.we) begin
      if (eff_addr == TPS_ADDR_BANK_POINTER) begin
        state_d.pointer = BUS.wdata;
      end else if (in_bank && bank == TPS_BANK_TIMER) begin
        case (eff_addr[3:0])
          TPS_IDX_TIMER8_CONTROL: state_d.t8ctl = BUS.wdata;
          TPS_IDX_SHARED_CONTROL: state_d.shared = BUS.wdata;
          TPS_IDX_TIMER16_CONTROL: state_d.t16ctl = BUS.wdata;
          default: state_d.t8ctl = state_q.t8ctl;
        endcase
      end
    end
    state_d.capt_irq = demod_mode & TIMERS.short_capture & state_q.t8ctl[TPS_T8_CAPT_IE];
    state_d.tout_irq = TIMERS.short_timeout & state_q.t8ctl[TPS_T8_TOUT_IE];
    // Routing uses the settings in force, so a pin follows its control one cycle later.
    state_d.pout[4] = state_q.t8ctl[TPS_T8_OUT4] ? TIMERS.short_out : PORT3_LATCH[0];
    state_d.pout[5] = state_q.t16ctl[TPS_T16_OUT5] ? TIMERS.long_out : PORT3_LATCH[1];
    state_d.pout[6] = (!demod_mode && state_q.shared[TPS_SC_OUT6]) ? combined : PORT3_LATCH[2];
    state_d.pout[7] = PORT3_LATCH[3];
    state_d.comp_en = ~STOP_MODE;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= '{pointer: TPS_RESET_POINTER, t8ctl: TPS_RESET_CONTROL, shared: TPS_RESET_CONTROL,
                   t16ctl: TPS_RESET_CONTROL, rdata: TPS_RESET_BYTE, capt_irq: 1'b0, tout_irq: 1'b0,
                   pout: 4'h0, comp_en: 1'b1};
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // Plain storage, left without reset.
  always_ff @(posedge MCLK) begin
    if (CE && BUS.we && eff_addr != TPS_ADDR_BANK_POINTER) begin
      if (!in_bank) begin
        regfile_q[eff_addr] <= BUS.wdata;
      end else if (bank == TPS_BANK_F) begin
        bankf_q[eff_addr[3:0]] <= BUS.wdata;
      end
    end
  end

  assign RDATA = state_q.rdata;
  assign CAPTURE_IRQ = state_q.capt_irq;
  assign TIMEOUT_IRQ = state_q.tout_irq;
  assign PORT3_OUT = state_q.pout;
  assign COMPARATOR_EN = state_q.comp_en;
  assign BANK_POINTER = state_q.pointer;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_ptr_wr;
    CE && BUS.we && BUS.addr == TPS_ADDR_BANK_POINTER;
  endsequence

  property p_comp_off;
    @(posedge MCLK) disable iff (!RST_N) CE && STOP_MODE |=> !COMPARATOR_EN;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("comparators on in stop mode");

  property p_ptr;
    @(posedge MCLK) disable iff (!RST_N) s_ptr_wr |=> BANK_POINTER == $past(BUS.wdata);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write lost");

  property p_tout;
    @(posedge MCLK) disable iff (!RST_N)
      CE && TIMERS.short_timeout |=> TIMEOUT_IRQ == $past(state_q.t8ctl[TPS_T8_TOUT_IE]);
  endproperty
  a_tout: assert property (p_tout) else $error("timeout irq wrong");

  property p_capt;
    @(posedge MCLK) disable iff (!RST_N) CE && !state_q.t8ctl[TPS_T8_CAPT_IE] |=> !CAPTURE_IRQ;
  endproperty
  a_capt: assert property (p_capt) else $error("capture irq while masked");

  property p_out4;
    @(posedge MCLK) disable iff (!RST_N)
      CE && state_q.t8ctl[TPS_T8_OUT4] |=> PORT3_OUT[4] == $past(TIMERS.short_out);
  endproperty
  a_out4: assert property (p_out4) else $error("out4 not timer8");

  property p_out6;
    @(posedge MCLK) disable iff (!RST_N)
      CE && !demod_mode && state_q.shared[TPS_SC_OUT6] |=> PORT3_OUT[6] == $past(combined);
  endproperty
  a_out6: assert property (p_out6) else $error("out6 not combined");

  property p_and;
    @(posedge MCLK) disable iff (!RST_N)
      state_q.shared[TPS_SC_SEL_HI:TPS_SC_SEL_LO] == TPS_COMB_AND |->
        combined == (TIMERS.short_out & TIMERS.long_out);
  endproperty
  a_and: assert property (p_and) else $error("combine wrong");

  property p_demod_edge;
    @(posedge MCLK) disable iff (!RST_N)
      !demod_mode || state_q.shared[TPS_SC_SEL_HI:TPS_SC_SEL_LO] == 2'h3 |-> !DEMOD_EDGE;
  endproperty
  a_demod_edge: assert property (p_demod_edge) else $error("edge outside demodulation");

endmodule : tps_shared_control
`default_nettype wire

/* File: tb/timer_pair_shared_control_tb.sv */
// Self-checking bench for the timer pair shared control block.
`timescale 1ns/10ps
`default_nettype none
module timer_pair_shared_control_tb
  import tps_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, p2 = 1'b0, stop = 1'b0;
  logic [3:0] p3in = '0, latch = '0;
  tps_timer_type tim = '0;
  tps_bus_type bus;
  logic [7:0] rdata, ptr, rv, r, e;
  logic [7:4] p3out;
  logic dedge, cirq, tirq, cmpen;
  int num_errors = 0, cmp_count = 0, cyc = 0, ne = 0, nc = 0, nt = 0;
  tps_cpu_model cpu (.clk(mclk), .bus(bus), .rdata(rdata));
  tps_shared_control uut (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .BUS(bus), .RDATA(rdata), .TIMERS(tim),
    .DEMOD_EDGE(dedge), .CAPTURE_IRQ(cirq), .TIMEOUT_IRQ(tirq), .PORT3_IN(p3in), .PORT2_BIT0(p2),
    .PORT3_LATCH(latch), .STOP_MODE(stop), .PORT3_OUT(p3out), .COMPARATOR_EN(cmpen), .BANK_POINTER(ptr));
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Pulse counters sample mid-cycle, away from the launching edge.
  always @(negedge mclk) begin
    ne += (dedge === 1'b1);
    nc += (cirq === 1'b1);
    nt += (tirq === 1'b1);
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 4000) begin
      num_errors++;
      close_out();
    end
  end
  function automatic logic comb(input logic [1:0] c, input logic a, input logic b);
    case (c)
      2'h0: return a & b;
      2'h1: return a | b;
      2'h2: return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction : comb
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask : w
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    cpu.rd(a, rv);
    chk(rv & m, exp & m, "read");
  endtask : rchk
  task automatic edg(input logic s, input logic v, input logic [7:0] exp);
    ne = 0;
    @(posedge mclk);
    if (s) begin
      p2 <= v;
    end else begin
      p3in[1] <= v;
    end
    w(4);
    chk(8'(ne), exp, "edge");
  endtask : edg
  task automatic pulse(input logic cap, input logic [7:0] ec, input logic [7:0] et);
    nc = 0;
    nt = 0;
    @(posedge mclk);
    tim.short_capture <= cap;
    tim.short_timeout <= ~cap;
    @(posedge mclk);
    tim.short_capture <= 1'b0;
    tim.short_timeout <= 1'b0;
    w(3);
    chk(8'(nc), ec, "capture irq");
    chk(8'(nt), et, "timeout irq");
  endtask : pulse
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3b0b74ae));
    r = 8'($urandom);
    w(10);
    rst_n <= 1'b1;
    chk(8'(cmpen), 8'h01, "cmp on");
    rchk(TPS_ADDR_BANK_POINTER, 8'hff, TPS_RESET_POINTER);
    cpu.wr(TPS_ADDR_BANK_POINTER, 8'h0d);
    w(1);
    chk(ptr, 8'h0d, "pointer");
    for (int i = 0; i < 3; i++) rchk(8'(i), 8'hff, 8'h00);
    cpu.wr(8'h01, r);
    rchk(8'h01, 8'hff, r);
    cpu.wr(8'h00, 8'hff);
    rchk(8'h00, 8'h07, 8'h07);
    cpu.wr(8'h02, 8'hff);
    rchk(8'h02, 8'h01, 8'h01);
    cpu.wr(8'h03, 8'hff);
    rchk(8'h03, 8'hff, 8'h00);
    cpu.wr(8'hfd, 8'h30);
    cpu.wr(8'he1, ~r);
    cpu.wr(8'hfd, 8'h00);
    cpu.wr(8'h01, 8'h5a);
    rchk(8'h31, 8'hff, ~r);
    rchk(8'h01, 8'hff, 8'h5a);
    cpu.wr(8'hfd, 8'h05);
    cpu.wr(8'h01, r);
    rchk(8'h01, 8'hff, 8'h00);
    cpu.wr(8'hfd, 8'h0f);
    cpu.wr(8'h02, ~r);
    rchk(8'h02, 8'hff, ~r);
    cpu.wr(8'hfd, 8'h0d);
    ce <= 1'b0;
    cpu.wr(8'hfd, 8'h77);
    @(posedge mclk);
    ce <= 1'b1;
    rchk(8'h01, 8'hff, r);
    $display("register tests done");
    latch <= 4'($urandom);
    cpu.wr(8'h00, 8'h01);
    cpu.wr(8'h02, 8'h01);
    for (int c = 0; c < 4; c++) begin
      cpu.wr(8'h01, {2'b01, 2'(c), 4'h0});
      for (int v = 0; v < 4; v++) begin
        @(posedge mclk);
        tim.short_out <= v[1];
        tim.long_out <= v[0];
        w(3);
        e = {4'h0, latch[3], comb(2'(c), v[1], v[0]), v[0], v[1]};
        chk({4'h0, p3out}, e, "pins");
      end
    end
    cpu.wr(8'h00, 8'h00);
    cpu.wr(8'h02, 8'h00);
    cpu.wr(8'h01, 8'h00);
    w(3);
    chk({4'h0, p3out}, {4'h0, latch}, "latch pins");
    $display("routing tests done");
    // The reserved edge code must detect nothing.
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        cpu.wr(8'h01, {1'b1, 1'(s), 2'(c), 4'h0});
        edg(1'(s), 1'b1, 8'(c == 1 || c == 2));
        edg(1'(s), 1'b0, 8'(c == 0 || c == 2));
      end
    end
    $display("edge tests done");
    cpu.wr(8'h00, 8'h06);
    pulse(1'b1, 8'h01, 8'h00);
    pulse(1'b0, 8'h00, 8'h01);
    cpu.wr(8'h00, 8'h00);
    pulse(1'b1, 8'h00, 8'h00);
    pulse(1'b0, 8'h00, 8'h00);
    // Captures only exist in demodulation mode; the timeout request does not depend on the mode.
    cpu.wr(8'h00, 8'h06);
    cpu.wr(8'h01, 8'h00);
    pulse(1'b1, 8'h00, 8'h00);
    pulse(1'b0, 8'h00, 8'h01);
    $display("interrupt tests done");
    // Software keeps the port inputs out of any stop wake role here.
    stop <= 1'b1;
    w(3);
    chk(8'(cmpen), 8'h00, "cmp stop");
    stop <= 1'b0;
    w(3);
    chk(8'(cmpen), 8'h01, "cmp run");
    $display("stop tests done");
    cpu.wr(8'h01, 8'hff);
    rst_n <= 1'b0;
    w(2);
    rst_n <= 1'b1;
    chk(8'(cmpen), 8'h01, "cmp reset");
    rchk(TPS_ADDR_BANK_POINTER, 8'hff, TPS_RESET_POINTER);
    cpu.wr(TPS_ADDR_BANK_POINTER, 8'h0d);
    rchk(8'h01, 8'hff, TPS_RESET_CONTROL);
    $display("reset tests done");
    close_out();
  end
endmodule : timer_pair_shared_control_tb
`default_nettype wire

/* File: tb/tps_cpu_model.sv */
// Core model that reads and writes the banked register file.
`timescale 1ns/10ps
`default_nettype none
module tps_cpu_model
  import tps_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register bus
  output var tps_bus_type bus,
  input wire logic [7:0] rdata
);
  initial bus = '0;
  // Released address and data show the inverse so stale values never pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, ~a};
    @(posedge clk);
    bus <= '{1'b0, 1'b0, ~a, a};
    @(posedge clk);
    #1 d = rdata;
  endtask : rd
endmodule : tps_cpu_model
`default_nettype wire
